// *** logic/dsf_defs.vh ***
// constants for the drive status flag generator
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH

// register offsets
`define DSF_REG_SEL_P1      8'h00
`define DSF_REG_SEL_P2      8'h01
`define DSF_REG_SEL_P3      8'h02
`define DSF_REG_SEL_P4      8'h03
`define DSF_REG_SEL_P5      8'h04
`define DSF_REG_SEL_RELAY   8'h05
`define DSF_REG_TIMEOUT     8'h06
`define DSF_REG_FAN_CTRL    8'h07
`define DSF_REG_FIN_LEVEL   8'h08
`define DSF_REG_LL_MODE     8'h09
`define DSF_REG_LL_LEVEL    8'h0a
`define DSF_REG_PROTO       8'h0b
`define DSF_REG_LIFE_MON    8'h10
`define DSF_REG_FLAGS       8'h11

// selection codes
`define DSF_CODE_NDC        8'h20
`define DSF_CODE_CAP        8'h27
`define DSF_CODE_FAN        8'h28
`define DSF_CODE_START      8'h29
`define DSF_CODE_OHF        8'h2a
`define DSF_CODE_LOC        8'h2b
`define DSF_CODE_RDY        8'h32
`define DSF_CODE_FWR        8'h33
`define DSF_CODE_RVR        8'h34
`define DSF_CODE_MJA        8'h35

// reset values and setting limits
`define DSF_RST_RELAY_SEL   8'h05
`define DSF_RST_TIMEOUT     14'h0000
`define DSF_RST_FIN_LEVEL   8'h78
`define DSF_RST_LL_MODE     1'h1
`define DSF_RST_LL_LEVEL    8'h0a
`define DSF_MAX_TIMEOUT     14'h270f
`define DSF_MAX_FIN_LEVEL   8'hc8
`define DSF_MAX_LL_LEVEL    8'h14

// fan drop at or below 75 percent: speed*4 <= nominal*3
`define DSF_FAN_NUM         10'h003
`define DSF_FAN_DEN         10'h004

// 10 ms timeout unit at 40 MHz
`define DSF_TICK_NS         10000000
`define DSF_CLK_NS          25
`define DSF_TICK_CYC        (`DSF_TICK_NS / `DSF_CLK_NS)

// fan control: stop while idle
`define DSF_FAN_CTRL_IDLE   2'h1
// protocol code for the rtu framing
`define DSF_PROTO_RTU       1'h1

`endif

// *** logic/dsf_net_watch.v ***
// reception timeout watcher for the serial link
`timescale 1ns/10ps
`include "dsf_defs.vh"
module dsf_net_watch #(
	parameter TICK_CYC = `DSF_TICK_CYC
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// configuration
	input  wire        rtu_mode,
	input  wire [13:0] timeout_10ms,
	// link events
	input  wire        frame_rx,
	// result
	output reg         disc_q
);
	reg [31:0] tick_q;
	reg [13:0] cnt_q;
	wire       tick;

	assign tick = (tick_q == TICK_CYC - 1);

	// zero timeout means watching disabled
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 32'h0;
			cnt_q  <= 14'h0;
			disc_q <= 1'b0;
		end else if (!rtu_mode || timeout_10ms == 14'h0) begin
			// RULE_03 rtu only
			tick_q <= 32'h0;
			cnt_q  <= 14'h0;
			disc_q <= 1'b0;
		end else if (frame_rx) begin
			// RULE_04 frame releases
			tick_q <= 32'h0;
			cnt_q  <= 14'h0;
			disc_q <= 1'b0;
		end else begin
			tick_q <= tick ? 32'h0 : tick_q + 32'h1;
			if (tick && !disc_q) begin
				// RULE_05 settable timeout
				if (cnt_q + 14'h1 >= timeout_10ms)
					disc_q <= 1'b1;
				else
					cnt_q <= cnt_q + 14'h1;
			end
		end
	end
endmodule // dsf_net_watch

// *** logic/dsf_status_flags.v ***
// status flag generator with output terminal routing
`timescale 1ns/10ps
`include "dsf_defs.vh"

// Behaviour
// RULE_01 - capacitor life warning from temperature and powered-time estimate, code 39
// RULE_02 - life monitor shows capacitor and fan life warnings; code shows the fan drop flag fan_f, not fan_life_expired
// RULE_03 - network disconnect flag, code 32, only in rtu protocol
// RULE_04 - after timeout flag holds until next frame received
// RULE_05 - timeout setting 0.00 to 99.99 s, default 0.00
// RULE_06 - fan drop flag, code 40, at or below 75 percent speed
// RULE_07 - fan control 01: stopped fan raises no drop flag
// RULE_08 - starting contact flag, code 41, while run command received
// RULE_09 - starting contact flag works for any command source
// RULE_10 - forward and reverse both active stops the drive
// RULE_11 - fin overheat flag, code 42, above level 0..200, default 120
// RULE_12 - light load flag, code 43, current below detect level
// RULE_13 - light load mode 00 any run, 01 constant speed; default 01
// RULE_14 - light load level 0.0 to 2.0 times rated, default rated
// RULE_15 - ready flag, code 50, when run command can be accepted
// RULE_16 - run command ignored while not ready
// RULE_17 - forward running flag, code 51, only while running forward
// RULE_18 - reverse running flag, code 52, only while running reverse
// RULE_19 - fatal fault flag, code 53, alarm plus hardware trip
// RULE_20 - each flag selectable on five terminals and relay, relay default 05
// RULE_21 - each terminal drives the flag its selection code names
module dsf_status_flags #(
	parameter TICK_CYC = `DSF_TICK_CYC,
	parameter NTERM    = 6
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata_q,
	// measurements
	input  wire        cap_life_expired,
	input  wire        fan_life_expired,
	input  wire [7:0]  fin_temp_c,
	input  wire [7:0]  fan_speed,
	input  wire [7:0]  fan_speed_nom,
	input  wire        fan_running,
	input  wire [7:0]  out_current,
	input  wire        at_const_speed,
	input  wire        supply_ok,
	// run commands
	input  wire        forward_run_input,
	input  wire        reverse_run_input,
	// faults
	input  wire        alarm,
	input  wire        trip_ct,
	input  wire        trip_cpu,
	input  wire        trip_ground,
	input  wire        trip_fan_stop,
	input  wire        trip_gate_array,
	input  wire        trip_main_circuit,
	// link
	input  wire        frame_rx,
	// outputs
	output reg  [4:0]  term_out_q,
	output reg         relay_out_q,
	output reg         run_fwd_q,
	output reg         run_rev_q
);
	reg  [7:0]  sel_q [0:NTERM-1];
	reg  [13:0] timeout_q;
	reg  [1:0]  fan_ctrl_q;
	reg  [7:0]  fin_level_q;
	reg         ll_mode_q;
	reg  [7:0]  ll_level_q;
	reg         proto_q;
	reg  [15:0] rdata_d;
	wire        network_disconnect_flag;
	wire [9:0]  flags;
	integer     i;
	integer     j;

	// pick one flag by selection code; unknown codes read low
	function sel_flag;
		input [7:0] code;
		input [9:0] f;
		begin
			case (code)
			`DSF_CODE_CAP:   sel_flag = f[0];
			`DSF_CODE_NDC:   sel_flag = f[1];
			`DSF_CODE_FAN:   sel_flag = f[2];
			`DSF_CODE_START: sel_flag = f[3];
			`DSF_CODE_OHF:   sel_flag = f[4];
			`DSF_CODE_LOC:   sel_flag = f[5];
			`DSF_CODE_RDY:   sel_flag = f[6];
			`DSF_CODE_FWR:   sel_flag = f[7];
			`DSF_CODE_RVR:   sel_flag = f[8];
			`DSF_CODE_MJA:   sel_flag = f[9];
			default:         sel_flag = 1'b0;
			endcase
		end
	endfunction

	dsf_net_watch #(
		.TICK_CYC     (TICK_CYC)
	) u_net (
		.clk          (clk),
		.rst_n        (rst_n),
		.rtu_mode     (proto_q == `DSF_PROTO_RTU),
		.timeout_10ms (timeout_q),
		.frame_rx     (frame_rx),
		.disc_q       (network_disconnect_flag)
	);

	// flag derivation
	reg        cap_f, fan_f, start_f, ohf_f, loc_f, rdy_f, mja_f;
	reg        run_cmd;
	reg [9:0]  fan_lhs, fan_rhs;
	always @* begin
		// RULE_19 hardware trips
		// worked out first, ready below depends on it
		mja_f   = alarm & (trip_ct | trip_cpu | trip_ground |
			trip_fan_stop | trip_gate_array | trip_main_circuit);
		// RULE_10 both stop
		// RULE_09 any source
		run_cmd = forward_run_input ^ reverse_run_input;
		// RULE_15 ready state
		rdy_f   = supply_ok & ~mja_f;
		// RULE_08 run received
		start_f = forward_run_input | reverse_run_input;
		// RULE_01 life estimate
		cap_f   = cap_life_expired;
		// RULE_06 75 percent
		fan_lhs = {2'b00, fan_speed} * `DSF_FAN_DEN;
		fan_rhs = {2'b00, fan_speed_nom} * `DSF_FAN_NUM;
		fan_f   = (fan_lhs <= fan_rhs);
		// RULE_07 idle fan
		if (fan_ctrl_q == `DSF_FAN_CTRL_IDLE && !fan_running)
			fan_f = 1'b0;
		// RULE_11 fin level
		ohf_f   = (fin_temp_c > fin_level_q);
		// RULE_12 below level
		// RULE_13 mode gate
		// RULE_14 level scale
		loc_f   = (run_fwd_q | run_rev_q) & (out_current < ll_level_q)
			& (~ll_mode_q | at_const_speed);
	end

	assign flags = {mja_f, run_rev_q, run_fwd_q, rdy_f, loc_f, ohf_f,
		start_f, fan_f, network_disconnect_flag, cap_f};

	// run state and terminal outputs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_fwd_q   <= 1'b0;
			run_rev_q   <= 1'b0;
			term_out_q  <= 5'h00;
			relay_out_q <= 1'b0;
		end else begin
			// RULE_16 not ready ignored
			// losing readiness also halts a running drive
			if (!run_cmd || !rdy_f) begin
				run_fwd_q <= 1'b0;
				run_rev_q <= 1'b0;
			end else begin
				// RULE_17 forward flag
				run_fwd_q <= forward_run_input;
				// RULE_18 reverse flag
				run_rev_q <= reverse_run_input;
			end
			// RULE_21 terminal routing
			for (i = 0; i < 5; i = i + 1)
				term_out_q[i] <= sel_flag(sel_q[i], flags);
			// RULE_20 relay selectable
			relay_out_q <= sel_flag(sel_q[5], flags);
		end
	end

	// register writes, out-of-range settings are clamped
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (j = 0; j < NTERM - 1; j = j + 1)
				sel_q[j] <= 8'h00;
			// RULE_20 relay default
			sel_q[NTERM-1] <= `DSF_RST_RELAY_SEL;
			timeout_q   <= `DSF_RST_TIMEOUT;
			fan_ctrl_q  <= 2'h0;
			fin_level_q <= `DSF_RST_FIN_LEVEL;
			ll_mode_q   <= `DSF_RST_LL_MODE;
			ll_level_q  <= `DSF_RST_LL_LEVEL;
			proto_q     <= `DSF_PROTO_RTU;
		end else if (reg_wr) begin
			case (reg_addr)
			`DSF_REG_SEL_P1:    sel_q[0] <= reg_wdata[7:0];
			`DSF_REG_SEL_P2:    sel_q[1] <= reg_wdata[7:0];
			`DSF_REG_SEL_P3:    sel_q[2] <= reg_wdata[7:0];
			`DSF_REG_SEL_P4:    sel_q[3] <= reg_wdata[7:0];
			`DSF_REG_SEL_P5:    sel_q[4] <= reg_wdata[7:0];
			`DSF_REG_SEL_RELAY: sel_q[5] <= reg_wdata[7:0];
			`DSF_REG_TIMEOUT: begin
				// RULE_05 range clamp
				if (reg_wdata[13:0] > `DSF_MAX_TIMEOUT)
					timeout_q <= `DSF_MAX_TIMEOUT;
				else
					timeout_q <= reg_wdata[13:0];
			end
			`DSF_REG_FAN_CTRL:  fan_ctrl_q <= reg_wdata[1:0];
			`DSF_REG_FIN_LEVEL: begin
				if (reg_wdata[7:0] > `DSF_MAX_FIN_LEVEL)
					fin_level_q <= `DSF_MAX_FIN_LEVEL;
				else
					fin_level_q <= reg_wdata[7:0];
			end
			`DSF_REG_LL_MODE:   ll_mode_q <= reg_wdata[0];
			`DSF_REG_LL_LEVEL: begin
				if (reg_wdata[7:0] > `DSF_MAX_LL_LEVEL)
					ll_level_q <= `DSF_MAX_LL_LEVEL;
				else
					ll_level_q <= reg_wdata[7:0];
			end
			`DSF_REG_PROTO:     proto_q <= reg_wdata[0];
			default: ;
			endcase
		end
	end

	// read mux
	always @* begin
		case (reg_addr)
		`DSF_REG_SEL_P1:    rdata_d = {8'h00, sel_q[0]};
		`DSF_REG_SEL_P2:    rdata_d = {8'h00, sel_q[1]};
		`DSF_REG_SEL_P3:    rdata_d = {8'h00, sel_q[2]};
		`DSF_REG_SEL_P4:    rdata_d = {8'h00, sel_q[3]};
		`DSF_REG_SEL_P5:    rdata_d = {8'h00, sel_q[4]};
		`DSF_REG_SEL_RELAY: rdata_d = {8'h00, sel_q[5]};
		`DSF_REG_TIMEOUT:   rdata_d = {2'h0, timeout_q};
		`DSF_REG_FAN_CTRL:  rdata_d = {14'h0, fan_ctrl_q};
		`DSF_REG_FIN_LEVEL: rdata_d = {8'h00, fin_level_q};
		`DSF_REG_LL_MODE:   rdata_d = {15'h0, ll_mode_q};
		`DSF_REG_LL_LEVEL:  rdata_d = {8'h00, ll_level_q};
		`DSF_REG_PROTO:     rdata_d = {15'h0, proto_q};
		// RULE_02 life monitor
		`DSF_REG_LIFE_MON:  rdata_d = {14'h0, fan_f, cap_f};
		`DSF_REG_FLAGS:     rdata_d = {6'h00, flags};
		default:            rdata_d = 16'h0000;
		endcase
	end

	// read data stands one cycle after the strobe only
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata_q <= 16'h0000;
		else if (reg_rd)
			reg_rdata_q <= rdata_d;
		else
			reg_rdata_q <= 16'h0000;
	end
endmodule // dsf_status_flags

// *** dv/dsf_status_flags_assertions.sv ***
// port checks for the status flag generator
`timescale 1ns/10ps
`include "dsf_defs.vh"
module dsf_status_flags_assertions (
	// clock and reset
	input logic        clk,
	input logic        rst_n,
	// register port
	input logic [7:0]  reg_addr,
	input logic [15:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [15:0] reg_rdata_q,
	// causes
	input logic        supply_ok,
	input logic        forward_run_input,
	input logic        reverse_run_input,
	input logic        alarm,
	input logic        trip_ct,
	// results
	input logic        relay_out_q,
	input logic        run_fwd_q,
	input logic        run_rev_q
);
	logic [7:0] rly_sel_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// shadow of the relay selection, written codes fit one byte
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rly_sel_q <= `DSF_RST_RELAY_SEL;
		else if (reg_wr && reg_addr == `DSF_REG_SEL_RELAY)
			rly_sel_q <= reg_wdata[7:0];
	end
	property p_both;
		forward_run_input && reverse_run_input |=> !run_fwd_q && !run_rev_q;
	endproperty
	a_both: assert property (p_both) else $error("both runs kept");
	property p_fwd;
		forward_run_input && !reverse_run_input && supply_ok && !alarm
			|=> run_fwd_q && !run_rev_q;
	endproperty
	a_fwd: assert property (p_fwd) else $error("no forward");
	property p_rev;
		reverse_run_input && !forward_run_input && supply_ok && !alarm
			|=> run_rev_q && !run_fwd_q;
	endproperty
	a_rev: assert property (p_rev) else $error("no reverse");
	property p_noready;
		!supply_ok |=> !run_fwd_q && !run_rev_q;
	endproperty
	a_noready: assert property (p_noready) else $error("ran unready");
	property p_rdclr;
		!reg_rd |=> reg_rdata_q == 16'h0000;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("stale read");
	property p_start;
		rly_sel_q == `DSF_CODE_START && !reg_wr
			&& (forward_run_input || reverse_run_input) |=> relay_out_q;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_fatal;
		rly_sel_q == `DSF_CODE_MJA && !reg_wr && alarm && trip_ct
			|=> relay_out_q;
	endproperty
	a_fatal: assert property (p_fatal) else $error("no fatal");
	property p_nofatal;
		rly_sel_q == `DSF_CODE_MJA && !reg_wr && !alarm |=> !relay_out_q;
	endproperty
	a_nofatal: assert property (p_nofatal) else $error("bad fatal");
	c_both: cover property (forward_run_input && reverse_run_input);
	c_fatal: cover property (rly_sel_q == `DSF_CODE_MJA && relay_out_q);
	c_read: cover property (reg_rd ##1 reg_rdata_q != 16'h0000);
endmodule // dsf_status_flags_assertions

// *** dv/dsf_term_watch.sv ***
// indicator model counting relay closures
`timescale 1ns/10ps
module dsf_term_watch (
	// clock and reset
	input logic        clk,
	input logic        rst_n,
	// watched terminal
	input logic        relay_out_q,
	// closures seen
	output logic [7:0] rises_q
);
	logic seen_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
			rises_q <= 8'h00;
		end else begin
			seen_q <= relay_out_q;
			if (relay_out_q && !seen_q)
				rises_q <= rises_q + 8'h01;
		end
	end
endmodule // dsf_term_watch

// *** dv/drive_status_output_flags_bench.sv ***
// bench for the status flag generator
`timescale 1ns/10ps
`include "dsf_defs.vh"
module drive_status_output_flags_bench;
	logic clk, rst_n, reg_wr, reg_rd, frame_rx, relay_out_q;
	logic [7:0] reg_addr, fin_temp_c, fan_speed, fan_speed_nom, out_current;
	logic [15:0] reg_wdata, reg_rdata_q;
	logic cap_life_expired, fan_life_expired, fan_running, at_const_speed;
	logic supply_ok, forward_run_input, reverse_run_input, alarm;
	logic trip_ct, trip_cpu, trip_ground, trip_fan_stop, trip_gate_array;
	logic trip_main_circuit, run_fwd_q, run_rev_q;
	logic [4:0] term_out_q;
	logic [5:0] trips;
	logic [7:0] rises_q, r0;
	int num_errors, tests_run, cycles;
	assign {trip_main_circuit, trip_gate_array, trip_fan_stop, trip_ground,
		trip_cpu, trip_ct} = trips;
	dsf_status_flags #(.TICK_CYC(4)) dut_u (.*);
	dsf_term_watch watch_u (.clk(clk), .rst_n(rst_n),
		.relay_out_q(relay_out_q), .rises_q(rises_q));
	task final_report;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		tests_run = tests_run + 1;
		if (s !== e) begin
			num_errors = num_errors + 1;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task rdc(input logic [7:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata_q, e);
		@(posedge clk);
	endtask
	// route a code to the relay, let it settle, compare
	task fl(input logic [7:0] code, input logic e);
		wr(`DSF_REG_SEL_RELAY, {8'h00, code});
		repeat (3) @(posedge clk);
		#1 chk({15'h0000, relay_out_q}, {15'h0000, e});
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			final_report;
		end
	end
	initial begin
		{rst_n, reg_wr, reg_rd, frame_rx, cap_life_expired, alarm} = 6'h00;
		{fan_life_expired, at_const_speed, forward_run_input} = 3'h0;
		{reverse_run_input, trips, reg_addr, reg_wdata} = 31'h0;
		{fan_running, supply_ok} = 2'h3;
		{fin_temp_c, fan_speed, fan_speed_nom} = 24'h196464;
		out_current = 8'h0a;
		{num_errors, tests_run, cycles} = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(`DSF_REG_SEL_RELAY, 16'h0005);
		rdc(`DSF_REG_TIMEOUT, 16'h0000);
		rdc(`DSF_REG_FIN_LEVEL, 16'h0078);
		rdc(8'h3f, 16'h0000);
		wr(`DSF_REG_FIN_LEVEL, 16'hffff);
		rdc(`DSF_REG_FIN_LEVEL, 16'h00c8);
		wr(`DSF_REG_LL_LEVEL, 16'hffff);
		rdc(`DSF_REG_LL_LEVEL, 16'h0014);
		wr(`DSF_REG_FIN_LEVEL, 16'h0078);
		wr(`DSF_REG_LL_LEVEL, 16'h000a);
		fl(`DSF_CODE_CAP, 1'b0);
		cap_life_expired <= 1'b1;
		fl(`DSF_CODE_CAP, 1'b1);
		for (int i = 0; i < 5; i++)
			wr(i[7:0], {8'h00, `DSF_CODE_CAP});
		#1 chk({11'h000, term_out_q}, 16'h001f);
		fan_speed <= 8'h4c;
		fl(`DSF_CODE_FAN, 1'b0);
		fan_speed <= 8'h4b;
		fl(`DSF_CODE_FAN, 1'b1);
		rdc(`DSF_REG_LIFE_MON, 16'h0003);
		wr(`DSF_REG_FAN_CTRL, 16'h0001);
		{fan_running, fan_speed} <= 9'h000;
		fl(`DSF_CODE_FAN, 1'b0);
		fin_temp_c <= 8'h78;
		fl(`DSF_CODE_OHF, 1'b0);
		fin_temp_c <= 8'h79;
		fl(`DSF_CODE_OHF, 1'b1);
		fl(`DSF_CODE_RDY, 1'b1);
		forward_run_input <= 1'b1;
		fl(`DSF_CODE_START, 1'b1);
		fl(`DSF_CODE_FWR, 1'b1);
		fl(`DSF_CODE_RVR, 1'b0);
		out_current <= 8'h09;
		fl(`DSF_CODE_LOC, 1'b0);
		at_const_speed <= 1'b1;
		fl(`DSF_CODE_LOC, 1'b1);
		at_const_speed <= 1'b0;
		wr(`DSF_REG_LL_MODE, 16'h0000);
		fl(`DSF_CODE_LOC, 1'b1);
		out_current <= 8'h0a;
		fl(`DSF_CODE_LOC, 1'b0);
		reverse_run_input <= 1'b1;
		fl(`DSF_CODE_FWR, 1'b0);
		forward_run_input <= 1'b0;
		fl(`DSF_CODE_RVR, 1'b1);
		fl(`DSF_CODE_FWR, 1'b0);
		{reverse_run_input, supply_ok} <= 2'h0;
		fl(`DSF_CODE_RDY, 1'b0);
		forward_run_input <= 1'b1;
		fl(`DSF_CODE_FWR, 1'b0);
		{forward_run_input, supply_ok} <= 2'h1;
		// three ticks, so a fresh timeout cannot land in the check
		wr(`DSF_REG_TIMEOUT, 16'h0003);
		repeat (20) @(posedge clk);
		fl(`DSF_CODE_NDC, 1'b1);
		frame_rx <= 1'b1;
		@(posedge clk);
		frame_rx <= 1'b0;
		@(posedge clk);
		#1 chk({15'h0000, relay_out_q}, 16'h0000);
		wr(`DSF_REG_PROTO, 16'h0000);
		repeat (20) @(posedge clk);
		fl(`DSF_CODE_NDC, 1'b0);
		alarm <= 1'b1;
		fl(`DSF_CODE_MJA, 1'b0);
		r0 = rises_q;
		for (int i = 0; i < 6; i++) begin
			trips <= 6'h01 << i;
			repeat (3) @(posedge clk);
			#1 chk({15'h0000, relay_out_q}, 16'h0001);
			@(posedge clk);
			trips <= 6'h00;
			repeat (3) @(posedge clk);
		end
		chk({8'h00, rises_q - r0}, 16'h0006);
		final_report;
	end
endmodule // drive_status_output_flags_bench
bind dsf_status_flags dsf_status_flags_assertions chk_u (.*);
